// ==== rtl/dor_pkg.sv ====
package dor_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_UNUSED_CFG = 8'h00;
	localparam logic [7:0] ADDR_POLARITY = 8'h04;
	localparam logic [7:0] ADDR_MAN_EN = 8'h08;
	localparam logic [7:0] ADDR_MAN_VAL = 8'h0C;
	localparam logic [7:0] ADDR_COMPAT = 8'h10;
	localparam logic [7:0] ADDR_ROUTE_EN = 8'h14;
	localparam logic [7:0] ADDR_ROUTE0 = 8'h18;
	localparam logic [7:0] ADDR_CMD = 8'h2C;
	localparam logic [7:0] ADDR_PIN_STATE = 8'h30;
	localparam logic [7:0] ADDR_CMD_SUB = 8'h34;
	localparam int NROUTE = 5;
	// Routed line positions inside the 32-bit output vector
	localparam int BRAKE_BIT = 0;
	localparam int OUT1_BIT = 16;
	// Source codes
	localparam logic [7:0] SRC_ONE = 8'h00;
	localparam logic [7:0] SRC_ZERO = 8'h01;
	localparam logic [7:0] SRC_ENC_LO = 8'h02;
	localparam logic [7:0] SRC_ENC_HI = 8'h08;
	localparam logic [7:0] SRC_POS_LO = 8'h09;
	localparam logic [7:0] SRC_POS_HI = 8'h0F;
	localparam int INV_BIT = 7;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_ROUTE = 16'h0100;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Frequency limits and clock
	localparam int CLK_HZ = 40_000_000;
	localparam int FAST_HZ = 10_000;
	localparam int SLOW_HZ = 500;
	localparam int FAST_MIN_CYC = CLK_HZ / (2 * FAST_HZ);
	localparam int SLOW_MIN_CYC = CLK_HZ / (2 * SLOW_HZ);

	typedef struct packed {
		logic [5:0] enc;
		logic [5:0] pos;
		logic enc_p;
		logic pos_p;
	} dor_div_t;

	typedef struct packed {
		logic aw_done;
		logic w_done;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] unused_cfg;
		logic [31:0] polarity;
		logic [31:0] man_en;
		logic [31:0] man_val;
		logic [31:0] compat;
		logic route_en;
		logic [NROUTE-1:0][15:0] route;
		logic [31:0] cmd;
		logic [31:0] cmd_sub;
		logic enc_s1;
		logic enc_s2;
		logic pos_s1;
		logic pos_s2;
		dor_div_t div;
		logic [NROUTE-1:0] rt_lvl;
		logic [NROUTE-1:0][15:0] hold_cnt;
		logic [31:0] level;
	} dor_state_t;
endpackage

// ==== rtl/dor_router.sv ====
`timescale 1ns/1ps

// Register map, one aligned 32-bit word per register:
//   0x00 unused configuration word, held for software only
//   0x04 polarity word, in normal mode a set bit inverts the commanded level of its line
//   0x08 manual enable word, in normal mode a set bit hands its line to the manual value
//   0x0C manual value word, the forced level of each line
//   0x10 compatibility word, held for software only
//   0x14 routing enable, bit 0 only
//   0x18 to 0x28 routing words: brake, then outputs one to four
//   0x2C output command word: brake at bit 0, output one at bit 16
//   0x30 present line levels, read only
//   0x34 command subword, the gate bits of routing mode
// Unmapped addresses answer with a slave error and writes to them are dropped.
//
// Register bus timing: a write answers two cycles after address and data are
// both taken, a read one cycle after its address; each answer stands until
// the master takes it. Only bit 0 of the routing enable word is stored, and
// only when its low byte lane is written.
//
// Routing word: the high byte picks the source, the low byte the gate bit.
//   0x00 constant one, 0x01 constant zero
//   0x02 to 0x08 encoder train divided by 1, 2, 4, 8, 16, 32, 64
//   0x09 to 0x0F position train divided by 1, 2, 4, 8, 16, 32, 64
//   anything higher is reserved and leaves the line off
// Gate bits 4:0 index the command subword; bit 7 turns the gate sense over.
//
// Routed lines hold each level for a minimum count of clock cycles, which caps
// the brake and outputs one and two at the fast rate and the others at the
// slow rate; a faster source is slowed, never passed through.
//
// Lines are open drain: a level of one releases a line to its pull-up and a
// level of zero turns its transistor on. No pin is sensed here, so a shorted
// or overloaded line is not reported to software.

module dor_router (
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pulse trains, asynchronous to aclk
	input wire logic encoder_pulse,
	input wire logic position_pulse,
	// Line levels and open-drain enables
	output logic [31:0] out_drain_oe,
	output logic [31:0] out_level
);
	dor_pkg::dor_state_t st_r;
	dor_pkg::dor_state_t st_nxt;

	// Every output comes from the one state register. The ready signals are
	// decoded from it directly, so a request is taken at the first edge it is
	// offered unless its item is already held or an answer is still waiting.
	// This keeps one write and one read in flight, which is all the register
	// bus needs, and avoids any address or data buffer.
	// Open drain: a low level means the transistor is on and pulls the pin
	assign out_level = st_r.level;
	assign out_drain_oe = ~st_r.level;
	assign s_axi_awready = !st_r.aw_done && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_done && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	// Byte-lane merge for register writes
	// Only lanes whose strobe is set take new data; routing words are merged at
	// full width and then cut to their sixteen stored bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Line position of each routed output
	// Brake on bit 0, output one on bit 16 and the rest on the bits above
	function automatic int line_of(input int k);
		int p;
		p = dor_pkg::BRAKE_BIT;
		if (k != 0) begin
			p = dor_pkg::OUT1_BIT + k - 1;
		end
		return p;
	endfunction

	// Shortest hold of one level on a routed line. The brake and outputs one and
	// two may toggle twenty times faster than outputs three and four; the slow
	// lines use the long count so their drivers are never asked for more.
	function automatic logic [15:0] min_hold(input int k);
		logic [15:0] c;
		c = 16'(dor_pkg::SLOW_MIN_CYC);
		if (k < 3) begin
			c = 16'(dor_pkg::FAST_MIN_CYC);
		end
		return c;
	endfunction

	// Pick a divided tap; index 0 is the undivided pulse train
	// Counter bit n toggles once every 2^n rising edges, so it is the train
	// divided by 2^(n+1); bit 5 gives the divide-by-64 output
	function automatic logic tap(input logic raw, input logic [5:0] cnt, input logic [2:0] sel);
		logic r;
		r = raw;
		if (sel != 3'd0) begin
			r = cnt[sel - 3'd1];
		end
		return r;
	endfunction

	// Source decode of one routing word; codes above the position range are
	// reserved and give a low level, so a stray value can never pulse a line
	function automatic logic source_level(input logic [7:0] src, input logic enc,
			input logic pos, input dor_pkg::dor_div_t dv);
		logic r;
		r = 1'b0;
		if (src == dor_pkg::SRC_ONE) begin
			r = 1'b1;
		end else if (src == dor_pkg::SRC_ZERO) begin
			r = 1'b0;
		end else if (src >= dor_pkg::SRC_ENC_LO && src <= dor_pkg::SRC_ENC_HI) begin
			r = tap(enc, dv.enc, 3'(src - dor_pkg::SRC_ENC_LO));
		end else if (src >= dor_pkg::SRC_POS_LO && src <= dor_pkg::SRC_POS_HI) begin
			r = tap(pos, dv.pos, 3'(src - dor_pkg::SRC_POS_LO));
		end else begin
			r = 1'b0;
		end
		return r;
	endfunction

	// Single combinational pass: every next-state field is derived here from the
	// registered state, the bus inputs and the pulse trains, so the register stage below stays
	// a plain copy and the reset values live in one place
	always_comb begin
		// Working values; the routing ones are reused for every line
		logic [31:0] cmd_lvl;
		logic [7:0] src;
		logic [7:0] gsel;
		logic gate;
		logic raw;
		logic want;
		logic [15:0] min_cyc;
		// Read answer and write merge in preparation
		logic [31:0] rv;
		logic [1:0] rr;
		logic [31:0] wr_word;
		logic enc_rise;
		logic pos_rise;
		cmd_lvl = '0;
		src = '0;
		gsel = '0;
		gate = 1'b0;
		raw = 1'b0;
		want = 1'b0;
		min_cyc = '0;
		rv = '0;
		rr = dor_pkg::RESP_OKAY;
		wr_word = '0;
		enc_rise = 1'b0;
		pos_rise = 1'b0;
		st_nxt = st_r;

		// Two-flop synchronisers for the pulse trains; edges seen on stage two
		// Only stage two feeds the edge detectors and the divide-by-one tap, so a
		// metastable first stage never reaches the counters; the price is a
		// latency of two cycles on every edge of the train
		st_nxt.enc_s1 = encoder_pulse;
		st_nxt.enc_s2 = st_r.enc_s1;
		st_nxt.pos_s1 = position_pulse;
		st_nxt.pos_s2 = st_r.pos_s1;
		st_nxt.div.enc_p = st_r.enc_s2;
		st_nxt.div.pos_p = st_r.pos_s2;
		enc_rise = st_r.enc_s2 && !st_r.div.enc_p;
		pos_rise = st_r.pos_s2 && !st_r.div.pos_p;
		// Synchronous binary counters: bit n is the train divided by 2^(n+1)
		// Counters run in both modes so a switch into routing finds them moving
		if (enc_rise) begin
			st_nxt.div.enc = st_r.div.enc + 6'd1;
		end
		if (pos_rise) begin
			st_nxt.div.pos = st_r.div.pos + 6'd1;
		end

		// Write channel: address and data taken in either order
		// The register update waits one cycle after both halves are held, so the
		// decode below reads registered address, data and strobes only; the
		// response is raised in the same cycle as the update
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_done = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_done = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.aw_done && st_r.w_done) begin
			st_nxt.aw_done = 1'b0;
			st_nxt.w_done = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = dor_pkg::RESP_OKAY;
			unique case (st_r.awaddr)
				dor_pkg::ADDR_UNUSED_CFG: st_nxt.unused_cfg = merge(st_r.unused_cfg,
					st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_POLARITY: st_nxt.polarity = merge(st_r.polarity,
					st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_MAN_EN: st_nxt.man_en = merge(st_r.man_en,
					st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_MAN_VAL: st_nxt.man_val = merge(st_r.man_val,
					st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_COMPAT: st_nxt.compat = merge(st_r.compat,
					st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_ROUTE_EN: begin
					if (st_r.wstrb[0]) begin
						st_nxt.route_en = st_r.wdata[0];
					end
				end
				dor_pkg::ADDR_CMD: st_nxt.cmd = merge(st_r.cmd, st_r.wdata, st_r.wstrb);
				dor_pkg::ADDR_CMD_SUB: st_nxt.cmd_sub = merge(st_r.cmd_sub,
					st_r.wdata, st_r.wstrb);
				default: begin
					// An address that matches no route word stays a slave error
					st_nxt.bresp = dor_pkg::RESP_SLVERR;
					for (int k = 0; k < dor_pkg::NROUTE; k++) begin
						if (st_r.awaddr == dor_pkg::ADDR_ROUTE0 + 8'(4 * k)) begin
							wr_word = merge({16'h0000, st_r.route[k]},
								st_r.wdata, st_r.wstrb);
							st_nxt.route[k] = wr_word[15:0];
							st_nxt.bresp = dor_pkg::RESP_OKAY;
						end
					end
				end
			endcase
		end
		// The response is dropped on the edge at which the master takes it
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Read channel: data registered one cycle after the address
		// A read of the level word returns the registered line levels, which
		// lag the registers by one cycle after a write in normal mode and by two or more in routing mode
		if (s_axi_arvalid && s_axi_arready) begin
			unique case (s_axi_araddr)
				dor_pkg::ADDR_UNUSED_CFG: rv = st_r.unused_cfg;
				dor_pkg::ADDR_POLARITY: rv = st_r.polarity;
				dor_pkg::ADDR_MAN_EN: rv = st_r.man_en;
				dor_pkg::ADDR_MAN_VAL: rv = st_r.man_val;
				dor_pkg::ADDR_COMPAT: rv = st_r.compat;
				dor_pkg::ADDR_ROUTE_EN: rv = {31'h0000_0000, st_r.route_en};
				dor_pkg::ADDR_CMD: rv = st_r.cmd;
				dor_pkg::ADDR_PIN_STATE: rv = st_r.level;
				dor_pkg::ADDR_CMD_SUB: rv = st_r.cmd_sub;
				default: begin
					rr = dor_pkg::RESP_SLVERR;
					for (int k = 0; k < dor_pkg::NROUTE; k++) begin
						if (s_axi_araddr == dor_pkg::ADDR_ROUTE0 + 8'(4 * k)) begin
							// Route words read back zero-extended
							rv = {16'h0000, st_r.route[k]};
							rr = dor_pkg::RESP_OKAY;
						end
					end
				end
			endcase
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rv;
			st_nxt.rresp = rr;
		end else if (st_r.rvalid && s_axi_rready) begin
			// No new address is taken while the data waits, so nothing is lost here
			st_nxt.rvalid = 1'b0;
		end

		// Normal mode: per-bit polarity then per-bit manual override
		// Both steps are bitwise, so no configuration bit can reach another line;
		// manual override comes last and therefore also beats the polarity word
		cmd_lvl = st_r.cmd ^ st_r.polarity;
		cmd_lvl = (st_r.man_en & st_r.man_val) | (~st_r.man_en & cmd_lvl);

		if (st_r.route_en) begin
			// Routing mode: unrouted lines stay off, the config words are bypassed
			// Each routed line is a two-stage path: the wanted level first passes the
			// rate limiter into rt_lvl, then reaches the line one cycle later. The
			// limiter trades edge timing for a guaranteed maximum toggle rate.
			st_nxt.level = '0;
			for (int k = 0; k < dor_pkg::NROUTE; k++) begin
				src = st_r.route[k][15:8];
				gsel = st_r.route[k][7:0];
				gate = st_r.cmd_sub[gsel[4:0]] ^ gsel[dor_pkg::INV_BIT];
				raw = source_level(src, st_r.enc_s2, st_r.pos_s2, st_r.div);
				want = gate && raw;
				// Rate limit: a line holds each level for its minimum half period
				// hold_cnt saturates instead of wrapping, so a line idle for a long
				// time may change at once when its source next moves
				min_cyc = min_hold(k);
				if (want != st_r.rt_lvl[k] && st_r.hold_cnt[k] >= min_cyc) begin
					st_nxt.rt_lvl[k] = want;
					st_nxt.hold_cnt[k] = 16'h0001;
				end else if (st_r.hold_cnt[k] != 16'hFFFF) begin
					st_nxt.hold_cnt[k] = st_r.hold_cnt[k] + 16'h0001;
				end
				st_nxt.level[line_of(k)] = st_r.rt_lvl[k];
			end
		end else begin
			// Leaving routing mode re-arms the limiters so a later entry starts free
			st_nxt.level = cmd_lvl;
			st_nxt.rt_lvl = '0;
			st_nxt.hold_cnt = '1;
		end
	end

	// All state registered in one place; synchronous active-low reset
	// Reset leaves every line at level zero, with the transistors on, until
	// software has written its configuration; routing words start as constant zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.unused_cfg <= dor_pkg::RST_WORD;
			st_r.polarity <= dor_pkg::RST_WORD;
			st_r.man_en <= dor_pkg::RST_WORD;
			st_r.man_val <= dor_pkg::RST_WORD;
			st_r.route <= {dor_pkg::NROUTE{dor_pkg::RST_ROUTE}};
			st_r.hold_cnt <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ==== sim/dor_checker.sv ====
`timescale 1ns/1ps
// Watches the register bus handshakes and the open-drain outputs of the router
module dor_checker (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [31:0] out_level,
	input logic [31:0] out_drain_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A line is pulled low exactly when its level is low; the pull-up gives the high
	drain_inverse_a: assert property (out_drain_oe == ~out_level)
		else $error("drain enable is not the inverse of the level");
	// Reset is checked with reset itself, so it overrides the default disable
	rst_level_a: assert property (disable iff (1'b0) !aresetn |=> out_level == 32'h0)
		else $error("level not cleared by reset");
	// Write answer two edges after address and data are taken together
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	// No new request may be taken while an answer is pending
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule

bind dor_router dor_checker dor_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .out_level, .out_drain_oe);

// ==== sim/dor_load_model.sv ====
`timescale 1ns/1ps
// External loads with a pull-up on every open-drain line: released lines read high
module dor_load_model (
	input logic [31:0] out_drain_oe,
	output logic [31:0] pin
);
	// A driven line sinks to low, never an unknown
	assign pin = ~out_drain_oe;
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// Directed checks of the output router through its register bus and its pins
module testbench;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, enc = 0, pos = 0;
	logic [31:0] wdata = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, got;
	logic [31:0] rdata, lvl, oe, pin;
	int n_mismatch = 0;
	int tests_run = 0;
	// Rows: register, value written, line levels expected afterwards
	logic [7:0] t_a [6] = '{dor_pkg::ADDR_CMD, dor_pkg::ADDR_POLARITY, dor_pkg::ADDR_MAN_EN,
		dor_pkg::ADDR_MAN_VAL, dor_pkg::ADDR_UNUSED_CFG, dor_pkg::ADDR_COMPAT};
	logic [31:0] t_d [6] = '{32'h0001_0001, 32'h1, 32'h0001_0001, 32'h0001_0001,
		32'hFFFF_FFFF, 32'hFFFF_FFFF};
	logic [31:0] t_l [6] = '{32'h0001_0001, 32'h0001_0000, 32'h0, 32'h0001_0001,
		32'h0001_0001, 32'h0001_0001};

	always #12.5 aclk = ~aclk;

	dor_router dor_router_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.encoder_pulse(enc), .position_pulse(pos), .out_drain_oe(oe), .out_level(lvl));
	dor_load_model dor_load_model_i (.out_drain_oe(oe), .pin(pin));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Address and data go out together; each is released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!(bvalid && bready) && n < 40);
		got = bresp;
		bready <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, bvalid});
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!(rvalid && rready) && n < 40);
		got = rresp;
		rready <= 1'b0;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk(nm, e, rdata);
		@(posedge aclk);
	endtask

	// Routed lines may hold a level for thousands of cycles, so poll with a wide margin
	task automatic wl(input int b, input logic e, input string nm);
		int n;
		n = 0;
		while (pin[b] !== e && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk(nm, {31'h0, e}, {31'h0, pin[b]});
	endtask

	task automatic test_done;
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog well beyond the longest expected run
	initial begin
		repeat (100000) @(posedge aclk);
		n_mismatch++;
		test_done;
	end

	// Main sequence: reset values, table rows, then routing cases
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("reset level", 32'h0, lvl);
		rd(dor_pkg::ADDR_POLARITY, dor_pkg::RST_WORD, "polarity");
		rd(dor_pkg::ADDR_ROUTE0, {16'h0, dor_pkg::RST_ROUTE}, "route0");
		rd(8'h3C, 32'h0, "hole");
		chk("hole rresp", {30'h0, dor_pkg::RESP_SLVERR}, {30'h0, got});
		wr(8'h3C, 32'hFFFF_FFFF);
		chk("hole bresp", {30'h0, dor_pkg::RESP_SLVERR}, {30'h0, got});
		for (int i = 0; i < 6; i++) begin
			wr(t_a[i], t_d[i]);
			repeat (2) @(posedge aclk);
			chk("level", t_l[i], lvl);
			chk("pin", t_l[i], pin);
		end
		rd(dor_pkg::ADDR_MAN_VAL, 32'h0001_0001, "readback");
		wr(dor_pkg::ADDR_CMD_SUB, 32'h1);
		wr(dor_pkg::ADDR_ROUTE_EN, 32'h1);
		wl(0, 1'b0, "brake zero");
		wr(dor_pkg::ADDR_ROUTE0, 32'h0);
		wl(0, 1'b1, "brake one");
		wr(dor_pkg::ADDR_CMD_SUB, 32'h0);
		wl(0, 1'b0, "gate off");
		wr(dor_pkg::ADDR_ROUTE0, 32'h0080);
		wl(0, 1'b1, "gate inverted");
		wr(dor_pkg::ADDR_ROUTE0, 32'h1080);
		wl(0, 1'b0, "reserved");
		wr(dor_pkg::ADDR_ROUTE0 + 8'h04, 32'h0280);
		enc <= 1'b1;
		wl(16, 1'b1, "enc high");
		enc <= 1'b0;
		wl(16, 1'b0, "enc low");
		wr(dor_pkg::ADDR_ROUTE0 + 8'h04, 32'h0980);
		pos <= 1'b1;
		wl(16, 1'b1, "pos high");
		rd(dor_pkg::ADDR_PIN_STATE, 32'h0001_0000, "level word");
		// Reset in mid-run: routing off and lines back to zero
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("mid reset level", 32'h0, lvl);
		rd(dor_pkg::ADDR_ROUTE_EN, 32'h0, "mid reset route_en");
		test_done;
	end
endmodule
